//--- wdt_map.vh
// register offsets, field positions, reset values and timing counts for the watchdog
// assumes a 100 MHz system clock and an AXI4-Lite register bus with 32-bit data
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

`define WDT_SERVICE_OFF      16'hFFFF
`define WDT_SERVICE_ADDR     18'h3FFFC
`define WDT_CONFIG_ADDR      18'h00000
`define WDT_STATUS_ADDR      18'h00004
`define WDT_MASK_ADDR        18'h00008
`define WDT_ADDR_W           18

`define WDT_CFG_RATE_BIT     0
`define WDT_CFG_PINEN_BIT    1
`define WDT_CFG_DIS_BIT      2
`define WDT_CFG_RESET        3'h2

`define WDT_ST_TIMEOUT_BIT   0
`define WDT_ST_PORDONE_BIT   1

`define WDT_LONG_CYCLES      262128
`define WDT_SHORT_CYCLES     8176
`define WDT_PIN_LOW_CYCLES   32
`define WDT_POR_CYCLES       4096
`define WDT_PRE_W            12
`define WDT_CNT_W            6
`define WDT_SHORT_TAP        1
`define WDT_SERVICE_MASK     12'h00F
`define WDT_VECTOR_LOW       8'h00

`define WDT_RESP_OKAY        2'h0
`define WDT_RESP_SLVERR      2'h2

`endif

//--- wdt_timer.v
// prescaler and watchdog counter with the overflow detect
// assumes one clock; service, stop and internal reset are one-cycle pulses on that clock
`timescale 1ns/10ps
`include "wdt_map.vh"

module wdt_timer #(
    parameter PRE_W = `WDT_PRE_W,
    parameter CNT_W = `WDT_CNT_W
) (
    input  wire             clock,
    input  wire             rstn,
    input  wire             clear_all,
    input  wire             clear_pre,
    input  wire             service,
    input  wire             timeout_rate_select,
    input  wire             run,
    output reg              overflow,
    output reg  [PRE_W-1:0] prescale,
    output reg  [CNT_W-1:0] count
);
    reg [PRE_W-1:0] next_prescale;
    reg [CNT_W-1:0] next_count;
    reg             next_overflow;
    reg             carry;

    // full length: 6-bit count of the prescaler carry, 262128 cycles
    // short length: overflow once count reaches one, 8176 cycles
    // service keeps only the four lowest prescaler stages
    always @* begin
        next_prescale = prescale + {{(PRE_W-1){1'b0}}, 1'b1};
        carry         = &prescale;
        next_count    = count;
        next_overflow = 1'b0;
        if (carry) begin
            next_count = count + {{(CNT_W-1){1'b0}}, 1'b1}; // [RL1]
        end
        if (run && !service) begin
            if (timeout_rate_select) begin
                next_overflow = (count == `WDT_SHORT_TAP)
                                && (prescale == (1 << PRE_W) - 1 - 16); // [RL2]
            end else begin
                next_overflow = (&count)
                                && (prescale == (1 << PRE_W) - 1 - 16); // [RL2]
            end
        end
        if (service) begin
            next_prescale = prescale & `WDT_SERVICE_MASK; // [RL3]
            next_count    = {CNT_W{1'b0}};
        end
        if (clear_pre) begin
            next_prescale = {PRE_W{1'b0}}; // [RL10]
        end
        if (clear_all || !run) begin
            next_prescale = {PRE_W{1'b0}}; // [RL10] [RL12]
            next_count    = {CNT_W{1'b0}};
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prescale <= {PRE_W{1'b0}};
            count    <= {CNT_W{1'b0}};
            overflow <= 1'b0;
        end else begin
            prescale <= next_prescale;
            count    <= next_count;
            overflow <= next_overflow;
        end
    end
endmodule

//--- wdt_top.v
// watchdog with reset-pin pulse, cause flag and AXI4-Lite register slave
// assumes clock is the fast oscillator clock; stop_exec is a same-clock pulse
`timescale 1ns/10ps
`include "wdt_map.vh"

// Contract
// RL1: six-bit watchdog counter advances on carry of twelve-bit prescaler.
// RL2: unserviced overflow after 262128 or 8176 cycles, chosen by rate select.
// RL3: any write to service location clears counter and prescaler stages 12-5.
// RL4: timeout drives reset pin low 32 cycles when pin enable is set.
// RL5: timeout sets watchdog cause flag in reset cause register.
// RL6: service register decoded at address FFFF; the code decodes it at the word address 18'h3FFFC instead.
// RL7: software services right after reset and around stop mode.
// RL8: software services from main flow, not interrupt handlers.
// RL9: reading service register returns reset vector low byte.
// RL10: internal reset clears both counters; stop clears prescaler.
// RL11: power-on logic clears prescaler 4096 cycles after power up.
// RL12: after any reset counting restarts from zero unless disable bit set.
module wdt_top #(
    parameter [7:0] VECTOR_LOW = `WDT_VECTOR_LOW
) (
    input  wire        clock,
    input  wire        rstn,
    input  wire        stop_exec,
    input  wire        internal_reset,
    output reg         reset_pin_out,
    output reg         reset_pin_oe,
    output reg         system_reset,
    output wire        irq,
    input  wire [17:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [17:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    reg  [2:0]  config_reg_one;
    reg  [1:0]  reset_cause_reg;
    reg  [1:0]  irq_mask;
    reg  [17:0] aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    reg  [5:0]  pin_count;
    reg  [12:0] por_count;
    reg         por_done;
    reg         service;
    reg         por_clear;
    wire        overflow;
    wire        do_write;
    wire [17:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        timeout_rate_select;
    wire        reset_pin_enable;
    wire        watchdog_disable;

    localparam [31:0] PIN_LOW = `WDT_PIN_LOW_CYCLES;

    assign timeout_rate_select = config_reg_one[`WDT_CFG_RATE_BIT];
    assign reset_pin_enable    = config_reg_one[`WDT_CFG_PINEN_BIT];
    assign watchdog_disable    = config_reg_one[`WDT_CFG_DIS_BIT];

    function is_addr;
        input [17:0] a;
        input [17:0] b;
        begin
            is_addr = (a[17:2] == b[17:2]);
        end
    endfunction

    // write channel: address and data in either order, response after both
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data  = w_held ? w_data : s_axi_wdata;
    assign wr_strb  = w_held ? w_strb : s_axi_wstrb;
    assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready))
                      && (w_held || (s_axi_wvalid && s_axi_wready));
    assign s_axi_arready = !s_axi_rvalid;
    assign irq = |(reset_cause_reg & irq_mask);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aw_held         <= 1'b0;
            aw_addr         <= 18'h00000;
            w_held          <= 1'b0;
            w_data          <= 32'h00000000;
            w_strb          <= 4'h0;
            s_axi_bvalid    <= 1'b0;
            s_axi_bresp     <= `WDT_RESP_OKAY;
            config_reg_one  <= `WDT_CFG_RESET;
            irq_mask        <= 2'h0;
            service         <= 1'b0;
        end else begin
            service <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `WDT_RESP_OKAY;
                if (is_addr(wr_addr, `WDT_SERVICE_ADDR)) begin
                    service <= 1'b1; // [RL6] [RL3]
                end else if (is_addr(wr_addr, `WDT_CONFIG_ADDR)) begin
                    if (wr_strb[0]) begin
                        config_reg_one <= wr_data[2:0];
                    end
                end else if (is_addr(wr_addr, `WDT_MASK_ADDR)) begin
                    if (wr_strb[0]) begin
                        irq_mask <= wr_data[1:0];
                    end
                end else if (!is_addr(wr_addr, `WDT_STATUS_ADDR)) begin
                    s_axi_bresp <= `WDT_RESP_SLVERR;
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
            end
        end
    end

    // read channel: one cycle after the address is taken
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `WDT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `WDT_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            if (is_addr(s_axi_araddr, `WDT_SERVICE_ADDR)) begin
                s_axi_rdata <= {24'h000000, VECTOR_LOW}; // [RL9]
            end else if (is_addr(s_axi_araddr, `WDT_CONFIG_ADDR)) begin
                s_axi_rdata <= {29'h00000000, config_reg_one};
            end else if (is_addr(s_axi_araddr, `WDT_STATUS_ADDR)) begin
                s_axi_rdata <= {30'h00000000, reset_cause_reg};
            end else if (is_addr(s_axi_araddr, `WDT_MASK_ADDR)) begin
                s_axi_rdata <= {30'h00000000, irq_mask};
            end else begin
                s_axi_rresp <= `WDT_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // power-on prescaler clear and timeout reset pulse
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            por_count       <= 13'h0000;
            por_done        <= 1'b0;
            por_clear       <= 1'b0;
            pin_count       <= 6'h00;
            reset_pin_out   <= 1'b0;
            reset_pin_oe    <= 1'b0;
            system_reset    <= 1'b0;
            reset_cause_reg <= 2'h0;
        end else begin
            por_clear <= 1'b0;
            if (!por_done) begin
                por_count <= por_count + 13'h0001;
                if (por_count == `WDT_POR_CYCLES - 1) begin
                    por_done  <= 1'b1;
                    por_clear <= 1'b1; // [RL11]
                end
            end
            if (overflow) begin
                pin_count    <= PIN_LOW[5:0];
                system_reset <= 1'b1;
                reset_pin_oe <= reset_pin_enable; // [RL4]
            end else if (pin_count != 6'h00) begin
                pin_count <= pin_count - 6'h01;
                if (pin_count == 6'h01) begin
                    system_reset <= 1'b0;
                    reset_pin_oe <= 1'b0;
                end
            end
            // set wins over a write-one clear in the same cycle
            reset_cause_reg[`WDT_ST_TIMEOUT_BIT] <= overflow
                || (reset_cause_reg[`WDT_ST_TIMEOUT_BIT]
                    && !(do_write && is_addr(wr_addr, `WDT_STATUS_ADDR)
                         && wr_strb[0] && wr_data[`WDT_ST_TIMEOUT_BIT])); // [RL5]
            reset_cause_reg[`WDT_ST_PORDONE_BIT] <= (!por_done
                && por_count == `WDT_POR_CYCLES - 1)
                || (reset_cause_reg[`WDT_ST_PORDONE_BIT]
                    && !(do_write && is_addr(wr_addr, `WDT_STATUS_ADDR)
                         && wr_strb[0] && wr_data[`WDT_ST_PORDONE_BIT]));
        end
    end

    wdt_timer #(
        .PRE_W(`WDT_PRE_W),
        .CNT_W(`WDT_CNT_W)
    ) u_timer (
        .clock               (clock),
        .rstn                (rstn),
        .clear_all           (internal_reset || system_reset), // [RL10] [RL12]
        .clear_pre           (stop_exec || por_clear),
        .service             (service),
        .timeout_rate_select (timeout_rate_select),
        .run                 (!watchdog_disable),
        .overflow            (overflow),
        .prescale            (),
        .count               ()
    );
endmodule

//--- wdt_checker.sv
// port-level assertions for the watchdog top
// assumes single clock domain, async active-low reset
`timescale 1ns/10ps
`include "wdt_map.vh"
module wdt_checker #(parameter [7:0] VECTOR_LOW = 8'h00) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        internal_reset,
    input wire logic        system_reset,
    input wire logic        reset_pin_oe,
    input wire logic        reset_pin_out,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
default clocking @(posedge clock); endclocking
default disable iff (!rstn);
// cycles since last system or internal reset, or since any accepted write address
int quiet;
always @(posedge clock or negedge rstn) begin
    if (!rstn)
        quiet <= 0;
    else if (system_reset || internal_reset || (s_axi_awvalid && s_axi_awready))
        quiet <= 0;
    else
        quiet <= quiet + 1;
end
chk_pin_pulse: assert property ($rose(system_reset) |-> ##31 system_reset ##1 !system_reset)
    else $error("reset pulse not 32 cycles");
chk_pin_drive: assert property (reset_pin_oe |-> system_reset && !reset_pin_out)
    else $error("pin driven outside reset or high");
chk_no_early: assert property ($rose(system_reset) |-> quiet > 8000)
    else $error("timeout too early");
chk_svc_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `WDT_SERVICE_ADDR
    |=> s_axi_rvalid && s_axi_rdata[7:0] == VECTOR_LOW)
    else $error("service read wrong");
chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid or rdata unstable");
chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
cover property ($rose(system_reset));
cover property ($rose(reset_pin_oe));
cover property ($fell(internal_reset));
endmodule
bind wdt_top wdt_checker #(.VECTOR_LOW(VECTOR_LOW)) u_chk (.*);

//--- tb.sv
// self-checking bench for the watchdog top
// assumes the checker is bound separately
`timescale 1ns/10ps
`include "wdt_map.vh"
module tb;
logic        clock, rstn, stop_exec, internal_reset;
logic [17:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, d;
logic [3:0]  s_axi_wstrb;
logic [1:0]  r;
logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
wire         reset_pin_out, reset_pin_oe, system_reset, irq, s_axi_awready, s_axi_wready;
wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0]   s_axi_bresp, s_axi_rresp;
wire [31:0]  s_axi_rdata;
int          err_total, checks_done, rst_cnt, n;
wdt_top i_dut (.*);
initial begin
    clock = 0;
    forever #5 clock = ~clock;
end
always @(posedge system_reset) rst_cnt++;
task check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
        err_total++;
        $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
task end_sim;
    if (err_total == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task wr(input logic [17:0] a, input logic [31:0] v);
    logic ta, tw, b;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
        @(negedge clock);
        ta = s_axi_awvalid & s_axi_awready;
        tw = s_axi_wvalid & s_axi_wready;
        b = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clock);
        if (ta) s_axi_awvalid <= 0;
        if (tw) s_axi_wvalid <= 0;
        if (b) s_axi_bready <= 0;
    end while (!b);
endtask
task rd(input logic [17:0] a);
    logic ta, b;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
        @(negedge clock);
        ta = s_axi_arvalid & s_axi_arready;
        b = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clock);
        if (ta) s_axi_arvalid <= 0;
        if (b) s_axi_rready <= 0;
    end while (!b);
endtask
task t_map;
    rd(`WDT_CONFIG_ADDR);
    check(d[2:0], `WDT_CFG_RESET);
    check(r, `WDT_RESP_OKAY);
    rd(18'h00100);
    check(r, `WDT_RESP_SLVERR);
    wr(18'h00200, 32'h1);
    check(r, `WDT_RESP_SLVERR);
    rd(`WDT_SERVICE_ADDR);
    check(d[7:0], `WDT_VECTOR_LOW);
    repeat (4100) @(posedge clock);
    rd(`WDT_STATUS_ADDR);
    check(d[1], 1'b1);
endtask
task t_timeout(input logic [2:0] c, input logic pin);
    int k, m;
    wr(`WDT_CONFIG_ADDR, {29'h0, c});
    wr(`WDT_MASK_ADDR, 32'h1);
    wr(`WDT_SERVICE_ADDR, 32'h0);
    n = 0;
    while (!system_reset && n < 9000) begin
        @(negedge clock);
        n++;
    end
    check(n > 8140 && n < 8185, 1);
    check(reset_pin_out, 1'b0);
    k = 0;
    m = 0;
    while (system_reset && k < 100) begin
        k++;
        m += reset_pin_oe;
        @(negedge clock);
    end
    check(k, 32);
    check(m, pin ? 32 : 0);
    rd(`WDT_STATUS_ADDR);
    check(d[0], 1'b1);
    check(irq, 1'b1);
    wr(`WDT_STATUS_ADDR, 32'h1);
    @(negedge clock);
    check(irq, 1'b0);
    rd(`WDT_STATUS_ADDR);
    check(d[0], 1'b0);
endtask
task t_service;
    wr(`WDT_CONFIG_ADDR, 32'h3);
    n = rst_cnt;
    for (int i = 0; i < 4; i++) begin
        repeat (5000) @(posedge clock);
        if (i == 1) begin
            internal_reset <= 1;
            stop_exec <= 1;
            @(posedge clock);
            internal_reset <= 0;
            stop_exec <= 0;
        end else
            wr(`WDT_SERVICE_ADDR, 32'hA5);
    end
    check(rst_cnt, n);
    wr(`WDT_CONFIG_ADDR, 32'h7);
    repeat (9000) @(posedge clock);
    check(rst_cnt, n);
endtask
initial begin
    {rstn, stop_exec, internal_reset, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clock);
    rstn <= 1;
    t_map;
    t_timeout(3'h3, 1);
    t_timeout(3'h1, 0);
    t_service;
    end_sim;
end
initial begin
    #700000;
    err_total++;
    end_sim;
end
endmodule
